// ==== src/omc_mode_ctrl.sv ====
// Mode control register and operating-mode sequencer
module omc_mode_ctrl
    import omc_pkg::*;
#(
    parameter int STATUS_DELAY_CYCLES = omc_pkg::OMC_STATUS_CYCLES
)(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       hb_tick,
    input  wire logic       activity_seen,
    input  wire logic       sample_done,
    input  wire logic [7:0] burst_sample_count,
    output logic [2:0]      mode_select_field,
    output logic [2:0]      active_mode,
    output logic [2:0]      mode_status,
    output logic            clocks_run,
    output logic            partial_power_down,
    output logic            sampling_en,
    output logic            watch_en,
    output logic            fifo_en,
    output logic            x_channel_off,
    output logic            y_channel_off,
    output logic            z_channel_off,
    output logic [2:0]      axis_en,
    output logic            run_active
);
    import omc_pkg::*;

    // The settling counter is 24 bits wide
    if (STATUS_DELAY_CYCLES < 1 || STATUS_DELAY_CYCLES > 32'h00FFFFFF)
    begin
        $error("STATUS_DELAY_CYCLES out of range");
    end

    logic [2:0]  field_reg;
    logic [2:0]  axis_off_reg;
    logic        pend_reg;
    logic        pend_oneshot_reg;
    logic [2:0]  pend_mode_reg;
    logic [1:0]  hb_cnt_reg;
    logic [2:0]  active_reg;
    logic [2:0]  status_reg;
    logic [23:0] status_cnt_reg;
    omc_run_e    run_state_reg;
    logic [7:0]  run_left_reg;
    logic        run_cont_reg;
    logic [2:0]  run_return_reg;

    logic        ctrl_wr;
    logic [2:0]  wr_mode;
    logic        wr_cmd;
    logic        wr_mode_ok;
    logic        oneshot_ok;
    logic        apply;
    logic        watch_wake;
    logic        run_end;

    assign ctrl_wr    = wr_en && (wr_addr == OMC_CTRL_ADDR);
    assign wr_mode    = wr_data[OMC_MODE_LSB +: 3];
    assign wr_cmd     = wr_data[OMC_CMD_BIT];
    // Reserved codes are dropped before they reach the sequencer
    assign wr_mode_ok = (wr_mode != OMC_UNUSED_BIT_A) && (wr_mode != OMC_UNUSED_BIT_B);
    // One-shot accepted only with standby active and nothing pending
    assign oneshot_ok = ctrl_wr && wr_cmd && (active_reg == OMC_STANDBY)
                        && !pend_reg && (run_state_reg == OMC_IDLE);
    assign apply      = pend_reg && hb_tick && (hb_cnt_reg == OMC_HB_APPLY - 2'h1);
    assign watch_wake = (active_reg == OMC_WATCH) && activity_seen && !pend_reg;
    assign run_end    = (run_state_reg == OMC_RUN) && sample_done && !run_cont_reg
                        && (run_left_reg <= 8'h01);

    // Axis power-down bits take effect at once
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            axis_off_reg <= OMC_CTRL_RESET[OMC_Z_OFF_BIT:OMC_X_OFF_BIT];
        else if (ctrl_wr)
            axis_off_reg <= wr_data[OMC_Z_OFF_BIT:OMC_X_OFF_BIT];
    end

    // Mode field: host writes, hardware overrides on automatic events
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            field_reg <= OMC_CTRL_RESET[2:0];
        else if (ctrl_wr && !wr_cmd && wr_mode_ok)
            field_reg <= wr_mode;
        else if (oneshot_ok)
            field_reg <= OMC_COUNTED;
        else if (watch_wake)
            field_reg <= OMC_CONTINUOUS;
        else if (run_end)
            field_reg <= run_return_reg;
    end

    // Pending request waits for heartbeat ticks
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_reg         <= 1'b0;
            pend_oneshot_reg <= 1'b0;
            pend_mode_reg    <= OMC_CTRL_RESET[2:0];
            hb_cnt_reg       <= 2'h0;
        end
        else if (oneshot_ok)
        begin
            pend_reg         <= 1'b1;
            pend_oneshot_reg <= 1'b1;
            pend_mode_reg    <= OMC_COUNTED;
            hb_cnt_reg       <= 2'h0;
        end
        else if (ctrl_wr && !wr_cmd && wr_mode_ok)
        begin
            pend_reg         <= 1'b1;
            pend_oneshot_reg <= 1'b0;
            pend_mode_reg    <= wr_mode;
            hb_cnt_reg       <= 2'h0;
        end
        else if (apply)
        begin
            pend_reg   <= 1'b0;
            hb_cnt_reg <= 2'h0;
        end
        else if (pend_reg && hb_tick)
            hb_cnt_reg <= hb_cnt_reg + 2'h1;
    end

    // Active operating mode
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            active_reg <= OMC_CTRL_RESET[2:0];
        else if (apply)
            active_reg <= pend_mode_reg;
        else if (watch_wake)
            active_reg <= OMC_CONTINUOUS;
        else if (run_end)
            active_reg <= run_return_reg;
    end

    // Counted run: mode 111 returns to sleep, one-shot to standby
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_state_reg  <= OMC_IDLE;
            run_left_reg   <= 8'h00;
            run_cont_reg   <= 1'b0;
            run_return_reg <= OMC_SLEEP;
        end
        else if (apply && pend_mode_reg == OMC_COUNTED)
        begin
            run_state_reg  <= OMC_RUN;
            run_left_reg   <= burst_sample_count;
            run_cont_reg   <= (burst_sample_count == OMC_BURST_CONT);
            run_return_reg <= pend_oneshot_reg ? OMC_STANDBY : OMC_SLEEP;
        end
        else if (apply || run_end)
            run_state_reg <= OMC_IDLE;
        else if (run_state_reg == OMC_RUN && sample_done && !run_cont_reg)
            run_left_reg <= run_left_reg - 8'h01;
    end

    // Status follows the active mode after a settling delay
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_reg     <= OMC_CTRL_RESET[2:0];
            status_cnt_reg <= 24'h000000;
        end
        else if (status_reg == active_reg)
            status_cnt_reg <= 24'h000000;
        else if (status_cnt_reg >= 24'(STATUS_DELAY_CYCLES - 1))
        begin
            status_reg     <= active_reg;
            status_cnt_reg <= 24'h000000;
        end
        else
            status_cnt_reg <= status_cnt_reg + 24'h000001;
    end

    // Mode decode
    always_comb
    begin
        clocks_run         = (active_reg != OMC_SLEEP);
        partial_power_down = (active_reg == OMC_SLEEP);
        sampling_en        = (active_reg == OMC_CONTINUOUS) || (active_reg == OMC_COMBINED)
                             || (active_reg == OMC_COUNTED && run_state_reg == OMC_RUN);
        watch_en           = (active_reg == OMC_WATCH) || (active_reg == OMC_COMBINED);
        fifo_en            = (active_reg == OMC_COMBINED);
    end

    assign mode_select_field = field_reg;
    assign active_mode       = active_reg;
    assign mode_status       = status_reg;
    assign x_channel_off     = axis_off_reg[0];
    assign y_channel_off     = axis_off_reg[1];
    assign z_channel_off     = axis_off_reg[2];
    assign axis_en           = sampling_en ? ~axis_off_reg : 3'h0;
    assign run_active        = (run_state_reg == OMC_RUN);

    // Assertions
    // Request pending with no heartbeat and no run end: mode must hold
    sequence no_tick_s;
        pend_reg && !hb_tick && !run_end;
    endsequence

    // A new request restarts the heartbeat count
    logic [2:0] hb_seen_reg;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            hb_seen_reg <= 3'h0;
        else if (!pend_reg || oneshot_ok || (ctrl_wr && !wr_cmd && wr_mode_ok))
            hb_seen_reg <= 3'h0;
        else if (hb_tick)
            hb_seen_reg <= hb_seen_reg + 3'h1;
    end

    property sleep_p;
        @(posedge ref_clk) disable iff (!reset_n)
        (active_reg == OMC_SLEEP) |-> !clocks_run && partial_power_down && !sampling_en;
    endproperty

    sleep_decode_a: assert property (sleep_p) else $error("sleep decode wrong");
    standby_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (active_reg == OMC_STANDBY) |-> clocks_run && !sampling_en && !watch_en)
        else $error("standby decode wrong");
    watch_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (active_reg == OMC_WATCH) |-> watch_en && !sampling_en && !fifo_en)
        else $error("watch decode wrong");
    watch_wakeup_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (watch_wake && !ctrl_wr)
        |=> active_reg == OMC_CONTINUOUS && field_reg == OMC_CONTINUOUS)
        else $error("activity did not wake");
    cont_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (active_reg == OMC_CONTINUOUS) |-> sampling_en && !watch_en)
        else $error("continuous decode wrong");
    combined_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (active_reg == OMC_COMBINED) |-> sampling_en && watch_en && fifo_en)
        else $error("combined decode wrong");
    oneshot_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && wr_cmd && active_reg != OMC_STANDBY) |=> !(pend_reg && pend_oneshot_reg
        && $rose(pend_reg)))
        else $error("one-shot taken outside standby");
    run_return_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (run_end && !apply) |=> active_reg == $past(run_return_reg) && !run_active)
        else $error("run did not return");
    cont_run_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (run_active && run_cont_reg && !pend_reg) |=> run_active)
        else $error("continuous run stopped");
    hb_bound_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pend_reg |-> hb_seen_reg <= 3'(OMC_HB_MAX))
        else $error("mode change too slow");
    tick_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        no_tick_s |=> $stable(active_reg))
        else $error("mode changed without heartbeat");
    axis_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && sampling_en && $stable(active_reg)) |=> (axis_en == ~$past(wr_data[6:4])
        || !sampling_en))
        else $error("axis enables wrong");
    reserved_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && !wr_cmd && !wr_mode_ok && !pend_reg && !watch_wake && !run_end)
        |=> $stable(active_reg) && !pend_reg)
        else $error("reserved code changed mode");
endmodule

// ==== src/omc_pkg.sv ====
// Constants, codes and timing for the operating-mode control block
// Functional notes
// - Code 000: sleep, clocks stopped, partial power-down
// - Code 001: standby, clocks on, no sampling
// - Code 010: watch only, no sampling, no FIFO
// - Watch mode moves to continuous on activity
// - Code 101: continuous sampling, watch inactive
// - Code 110: watch, sampling and FIFO together
// - Command bit 7 starts counted run
// - Burst count 255 means sample continuously
// - One-shot run starts only from standby
// - One-shot run returns to standby when done
// - Bits 4..6 power down X, Y, Z
// - Mode change within three heartbeat ticks
// - Hardware may rewrite the mode field
// - Status follows mode after 2 to 10 ms
package omc_pkg;
    localparam logic [7:0] OMC_CTRL_ADDR     = 8'h10;
    localparam logic [7:0] OMC_CTRL_RESET    = 8'h00;
    localparam int         OMC_MODE_LSB      = 0;
    localparam int         OMC_X_OFF_BIT     = 4;
    localparam int         OMC_Y_OFF_BIT     = 5;
    localparam int         OMC_Z_OFF_BIT     = 6;
    localparam int         OMC_CMD_BIT       = 7;
    localparam logic [2:0] OMC_SLEEP         = 3'h0;
    localparam logic [2:0] OMC_STANDBY       = 3'h1;
    localparam logic [2:0] OMC_WATCH         = 3'h2;
    localparam logic [2:0] OMC_UNUSED_BIT_A        = 3'h3;
    localparam logic [2:0] OMC_UNUSED_BIT_B        = 3'h4;
    localparam logic [2:0] OMC_CONTINUOUS    = 3'h5;
    localparam logic [2:0] OMC_COMBINED      = 3'h6;
    localparam logic [2:0] OMC_COUNTED       = 3'h7;
    localparam logic [7:0] OMC_BURST_CONT    = 8'hFF;
    localparam logic [1:0] OMC_HB_APPLY      = 2'h2;
    localparam int         OMC_HB_MAX        = 3;
    localparam int         OMC_CLK_MHZ       = 100;
    localparam int         OMC_STATUS_MIN_US = 2000;
    localparam int         OMC_STATUS_MAX_US = 10000;
    localparam int         OMC_STATUS_CYCLES = OMC_STATUS_MIN_US * OMC_CLK_MHZ;
    typedef enum logic [1:0] {OMC_IDLE, OMC_RUN} omc_run_e;
endpackage

// ==== test/omc_host_model.sv ====
// Host model that issues single-cycle writes to the mode control register
module omc_host_model
    import omc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       go,
    input  wire logic [7:0] go_addr,
    input  wire logic [7:0] go_data,
    output logic            wr_en,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus inverts its previous value every cycle, so the last written value shows again every second idle cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_en   <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end
        else if (go)
        begin
            wr_en   <= 1'b1;
            wr_addr <= go_addr;
            wr_data <= go_data;
        end
        else
        begin
            wr_en   <= 1'b0;
            wr_addr <= ~wr_addr;
            wr_data <= ~wr_data;
        end
    end
endmodule

// ==== test/tb.sv ====
// Self-checking testbench for the operating-mode control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import omc_pkg::*;
    logic       ref_clk = 1'b0, reset_n = 1'b0, go = 1'b0, hb_tick = 1'b0;
    logic       activity_seen = 1'b0, sample_done = 1'b0, wr_en;
    logic [7:0] go_addr = 8'h00, go_data = 8'h00, wr_addr, wr_data;
    logic [7:0] burst_sample_count = 8'h00, ticks = 8'h00;
    logic [1:0] hb_cnt = 2'h0;
    logic [2:0] mode_select_field, active_mode, mode_status, axis_en;
    logic       clocks_run, partial_power_down, sampling_en, watch_en, fifo_en;
    logic       x_channel_off, y_channel_off, z_channel_off, run_active;
    int         errors = 0;
    int         checked = 0;
    logic [2:0] cd [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h5};
    logic [2:0] ax [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};

    omc_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .go_addr(go_addr),
        .go_data(go_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    omc_mode_ctrl #(.STATUS_DELAY_CYCLES(20)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .hb_tick(hb_tick),
        .activity_seen(activity_seen), .sample_done(sample_done),
        .burst_sample_count(burst_sample_count), .mode_select_field(mode_select_field),
        .active_mode(active_mode), .mode_status(mode_status), .clocks_run(clocks_run),
        .partial_power_down(partial_power_down), .sampling_en(sampling_en),
        .watch_en(watch_en), .fifo_en(fifo_en), .x_channel_off(x_channel_off),
        .y_channel_off(y_channel_off), .z_channel_off(z_channel_off), .axis_en(axis_en),
        .run_active(run_active));

    always #5 ref_clk = ~ref_clk;
    // Heartbeat every fourth cycle; ticks counts heartbeats since the last control-register write
    always @(posedge ref_clk)
    begin
        hb_cnt <= hb_cnt + 2'h1;
        hb_tick <= (hb_cnt == 2'h3);
        ticks <= (wr_en && wr_addr == OMC_CTRL_ADDR) ? 8'h00 : ticks + {7'h00, hb_tick};
    end

    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        go <= 1'b1;
        go_addr <= a;
        go_data <= d;
        @(posedge ref_clk);
        go <= 1'b0;
        cyc(1);
    endtask
    task automatic pulse;
        @(posedge ref_clk);
        sample_done <= 1'b1;
        @(posedge ref_clk);
        sample_done <= 1'b0;
        #1;
    endtask
    task automatic wait_mode(input logic [2:0] exp);
        int n;
        for (n = 0; n < 40 && active_mode !== exp; n++)
            cyc(1);
        chk(active_mode, exp);
        chk(ticks, 8'h02);
        if (active_mode !== exp)
            conclude();
    endtask
    task automatic wait_run;
        int n;
        for (n = 0; n < 40 && run_active !== 1'b1; n++)
            cyc(1);
        chk(run_active, 1'b1);
        if (run_active !== 1'b1)
            conclude();
    endtask
    function automatic logic [4:0] expv(input logic [2:0] c);
        return {c == 3'h5 || c == 3'h6, c == 3'h2 || c == 3'h6, c == 3'h6, c != 3'h0, c == 3'h0};
    endfunction

    initial
    begin
        #500000;
        chk(8'h00, 8'h01);
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(1);
        chk({active_mode, mode_select_field}, 8'h00);
        chk({clocks_run, partial_power_down}, 8'h01);
        wr(OMC_CTRL_ADDR, 8'h80);
        cyc(12);
        chk({run_active, active_mode}, 8'h00);
        wr(8'h11, 8'h05);
        cyc(12);
        chk({mode_select_field, active_mode}, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(OMC_CTRL_ADDR, {1'b0, ax[i], 1'b0, cd[i]});
            chk(mode_select_field, cd[i]);
            chk({z_channel_off, y_channel_off, x_channel_off}, ax[i]);
            wait_mode(cd[i]);
            chk({sampling_en, watch_en, fifo_en, clocks_run, partial_power_down},
                expv(cd[i]));
            chk(axis_en, expv(cd[i]) >= 5'h10 ? 3'(~ax[i]) : 3'h0);
            if (i == 0)
            begin
                chk(mode_status, OMC_SLEEP);
                for (int n = 0; n < 40 && mode_status !== OMC_STANDBY; n++)
                    cyc(1);
                chk(mode_status, OMC_STANDBY);
                if (mode_status !== OMC_STANDBY)
                    conclude();
            end
        end
        for (int r = 3; r < 5; r++)
        begin
            wr(OMC_CTRL_ADDR, r[7:0]);
            cyc(12);
            chk(active_mode, OMC_CONTINUOUS);
        end
        wr(OMC_CTRL_ADDR, {5'h00, OMC_WATCH});
        wait_mode(OMC_WATCH);
        @(posedge ref_clk);
        activity_seen <= 1'b1;
        @(posedge ref_clk);
        activity_seen <= 1'b0;
        #1;
        chk({active_mode, mode_select_field}, {2'h0, OMC_CONTINUOUS, OMC_CONTINUOUS});
        burst_sample_count <= 8'h03;
        wr(OMC_CTRL_ADDR, {5'h00, OMC_COUNTED});
        wait_mode(OMC_COUNTED);
        chk(sampling_en, 1'b1);
        pulse();
        pulse();
        chk(active_mode, OMC_COUNTED);
        pulse();
        chk({active_mode, mode_select_field}, 8'h00);
        wr(OMC_CTRL_ADDR, {5'h00, OMC_STANDBY});
        wait_mode(OMC_STANDBY);
        burst_sample_count <= 8'h02;
        wr(OMC_CTRL_ADDR, 8'h81);
        wait_run();
        chk(sampling_en, 1'b1);
        pulse();
        pulse();
        chk({run_active, active_mode}, {5'h00, OMC_STANDBY});
        burst_sample_count <= OMC_BURST_CONT;
        wr(OMC_CTRL_ADDR, 8'h81);
        wait_run();
        repeat (5) pulse();
        chk(run_active, 1'b1);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        cyc(2);
        chk({run_active, active_mode, partial_power_down}, 8'h01);
        @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(2);
        conclude();
    end
endmodule
